// ===== logic/brc_map.svh
/*
 * Constants of the buck regulator control logic: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz system clock and 32-bit APB; holds definitions only.
 */
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

// register byte offsets
`define BRC_CTRL_OFS 12'h000
`define BRC_STATUS_OFS 12'h004
`define BRC_HICCNT_OFS 12'h008
// control field positions and reset value
`define BRC_CTRL_RUN_BIT 0
`define BRC_CTRL_RST 32'h0000_0001
// status field positions
`define BRC_ST_STATE_LSB 0
`define BRC_ST_PGOOD_BIT 2
`define BRC_ST_HS_BIT 3
`define BRC_ST_LS_BIT 4
`define BRC_ST_ILIM_BIT 5
`define BRC_ST_PRESET_LSB 6
`define BRC_ST_MODE_LSB 10
`define BRC_ST_PGPIN_BIT 12
// clock period and timing figures
`define BRC_CLK_PERIOD_NS 5
`define BRC_HIC_BLANK_NS 12000
`define BRC_HIC_BLANK_CYC ((`BRC_HIC_BLANK_NS + `BRC_CLK_PERIOD_NS - 1) / `BRC_CLK_PERIOD_NS)
// counts in oscillator periods
`define BRC_HIC_OFF_PER 896
`define BRC_HIC_RETRY_PER 112
`define BRC_PG_DEGLITCH_PER 48

`endif

// ===== logic/brc_pkg.sv
/*
 * Types of the buck regulator control logic.
 * Assumes brc_map.svh for all numeric constants.
 */
package brc_pkg;
    // supervisor states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_HICCUP,
        ST_RETRY
    } brc_state_t;
    // operating mode chosen by the mode input
    typedef enum logic [1:0] {
        MD_PWM,
        MD_PWM_PREBIAS,
        MD_SKIP_PREBIAS,
        MD_RSVD
    } brc_mode_t;
endpackage

// ===== logic/brc_ctrl.sv
/*
 * Control logic of a synchronous step-down regulator: per-period switch
 * sequencing, current-limit hold, hiccup supervisor, power-good deglitch,
 * mode and preset decode, APB register slave.
 * Assumes comparator and pin inputs are asynchronous and get two flops;
 * three-level inputs arrive as 2-bit codes 00 ground, 01 open, 10 supply.
 */
// Chosen here: the APB slave port and the register addresses.
// What this block does
// - high side on at each period start
// - high side off on ramp or limit
// - low side on for period remainder
// - never both drivers on together
// - low side held until low-side current falls
// - 12us feedback low in limit enters hiccup
// - hiccup: drivers off, pull-downs on
// - 896 periods off then 112 retry
// - release power-good on 92.5% and reference ok
// - pull power-good on 90% or reference low
// - power-good changes after 48 periods persist
// - power-good low in shutdown, lockout, thermal
// - lockout inhibits switching; release starts soft-start
// - shutdown turns both drivers off
// - shutdown or hiccup pulls reference and compensation
// - three operating modes from mode input
// - two three-level inputs select nine presets
// - enable high runs, low shuts down
`timescale 1ns/10ps
`include "brc_map.svh"
module brc_ctrl #(
    parameter int PERIOD_CYC = 200,         // clocks per oscillator period
    parameter int DEAD_CYC = 2,             // break-before-make gap is this plus one clock
    parameter int HIC_BLANK_CYC = `BRC_HIC_BLANK_CYC
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic EN_I,                  // enable pin
    input wire logic UVLO_I,                // supply lockout active
    input wire logic THERM_SD_I,            // thermal shutdown active
    input wire logic PWM_CMP_I,             // ramp above compensation level
    input wire logic HS_ILIM_I,             // high-side current over limit
    input wire logic LS_ILIM_I,             // low-side current over limit
    input wire logic FB_LOW70_I,            // feedback below 70% of reference
    input wire logic FB_ABOVE925_I,         // feedback above 92.5% of reference
    input wire logic FB_BELOW90_I,          // feedback below 90% of reference
    input wire logic REF_OK_I,              // reference above 0.54 V
    input wire logic [1:0] MODE_I,
    input wire logic [1:0] PRESET_SELECT_A_I,
    input wire logic [1:0] PRESET_SELECT_B_I,
    input wire logic POWER_GOOD_OUT_I,      // pin level read back
    output logic POWER_GOOD_OUT_O,
    output logic POWER_GOOD_OUT_OE_O,       // high while pulling low
    output logic HS_DRV_O,
    output logic LS_DRV_O,
    output logic COMP_PD_O,
    output logic REF_PD_O,
    output logic SS_START_O,
    output logic SKIP_MODE_O,
    output logic PREBIAS_START_O,
    output logic [3:0] PRESET_CODE_O,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    // indices into the synchroniser vector
    localparam int NSYNC = 18;
    localparam int I_EN = 0;
    localparam int I_UVLO = 1;
    localparam int I_THERM = 2;
    localparam int I_CMP = 3;
    localparam int I_HSL = 4;
    localparam int I_LSL = 5;
    localparam int I_F70 = 6;
    localparam int I_F925 = 7;
    localparam int I_F90 = 8;
    localparam int I_REF = 9;
    localparam int I_PGP = 10;
    localparam int I_MODE = 11;
    localparam int I_PA = 13;
    localparam int I_PB = 15;
    localparam int HS_WAIT = DEAD_CYC + 2;  // tick to high side on, gap included

    // all state of the block
    typedef struct packed {
        logic [NSYNC-1:0] s1;               // first sync stage, read by s2 only
        logic [NSYNC-1:0] s2;
        logic [7:0] per_cnt;
        brc_pkg::brc_state_t st;
        logic hs_req;
        logic hs;
        logic ls;
        logic [3:0] dead;
        logic ls_hold;
        logic ilim_act;
        logic ilim_seen;
        logic [11:0] blank_cnt;
        logic [9:0] hic_cnt;
        logic [7:0] hic_events;
        logic pg;
        logic [5:0] pg_cnt;
        brc_pkg::brc_mode_t mode;
        logic skip;                         // decoded mode bits, kept as flops
        logic prebias;
        logic [3:0] preset;
        logic sw_run;
        logic ss_start;
        logic pd;
        logic pg_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } brc_regs_t;

    brc_regs_t r;
    brc_regs_t next_r;
    logic tick;                             // oscillator period start
    logic off_cond;
    logic allow;
    logic want_hs;
    logic [31:0] rdata;
    logic rmiss;

    // three-level pair to preset index 0..8
    function automatic logic [3:0] preset_of(input logic [1:0] a, input logic [1:0] b);
        logic [3:0] ta;
        logic [3:0] tb;
        ta = (a == 2'h2) ? 4'h2 : {3'h0, a[0]};
        tb = (b == 2'h2) ? 4'h2 : {3'h0, b[0]};
        return 4'((ta << 1) + ta + tb);
    endfunction

    // three-level mode code to operating mode
    function automatic brc_pkg::brc_mode_t mode_of(input logic [1:0] m);
        case (m)
            2'h0: return brc_pkg::MD_PWM;
            2'h1: return brc_pkg::MD_PWM_PREBIAS;
            default: return brc_pkg::MD_SKIP_PREBIAS;
        endcase
    endfunction

    // next-state logic for the whole block
    always_comb begin
        next_r = r;
        next_r.s1 = {PRESET_SELECT_B_I, PRESET_SELECT_A_I, MODE_I, POWER_GOOD_OUT_I, REF_OK_I, FB_BELOW90_I,
                     FB_ABOVE925_I, FB_LOW70_I, LS_ILIM_I, HS_ILIM_I, PWM_CMP_I, THERM_SD_I, UVLO_I, EN_I};
        next_r.s2 = r.s1;
        next_r.ss_start = 1'b0;
        want_hs = 1'b0;                     // only meaningful while switching is allowed
        tick = (r.per_cnt == 8'h00);
        next_r.per_cnt = (r.per_cnt == 8'(PERIOD_CYC - 1)) ? 8'h00 : 8'(r.per_cnt + 8'h01);
        off_cond = !r.s2[I_EN] || r.s2[I_UVLO] || r.s2[I_THERM];

        // current-limit episode: ends after a period without a trip
        if (r.s2[I_HSL]) begin
            next_r.ilim_act = 1'b1;
            next_r.ilim_seen = 1'b1;
        end else if (tick) begin
            next_r.ilim_act = r.ilim_seen;
            next_r.ilim_seen = 1'b0;
        end
        // blanking: feedback low must persist the whole window
        if (r.ilim_act && r.s2[I_F70] && (r.st == brc_pkg::ST_RUN || r.st == brc_pkg::ST_RETRY)) begin
            if (r.blank_cnt != 12'(HIC_BLANK_CYC))
                next_r.blank_cnt = 12'(r.blank_cnt + 12'h001);
        end else begin
            next_r.blank_cnt = 12'h000;
        end

        // supervisor
        case (r.st)
            brc_pkg::ST_OFF: begin
                next_r.mode = mode_of(r.s2[I_MODE+:2]);
                next_r.skip = (mode_of(r.s2[I_MODE+:2]) == brc_pkg::MD_SKIP_PREBIAS);
                next_r.prebias = (mode_of(r.s2[I_MODE+:2]) != brc_pkg::MD_PWM);
                next_r.preset = preset_of(r.s2[I_PA+:2], r.s2[I_PB+:2]);
                if (!off_cond) begin
                    next_r.st = brc_pkg::ST_RUN;
                    next_r.ss_start = 1'b1;
                end
            end
            brc_pkg::ST_RUN: begin
                if (r.blank_cnt == 12'(HIC_BLANK_CYC)) begin
                    next_r.st = brc_pkg::ST_HICCUP;
                    next_r.hic_cnt = 10'h000;
                    next_r.hic_events = (r.hic_events == 8'hff) ? r.hic_events : 8'(r.hic_events + 8'h01);
                end
            end
            brc_pkg::ST_HICCUP: begin
                next_r.blank_cnt = 12'h000;
                if (tick) begin
                    next_r.hic_cnt = 10'(r.hic_cnt + 10'h001);
                    if (r.hic_cnt == 10'(`BRC_HIC_OFF_PER - 1)) begin
                        next_r.st = brc_pkg::ST_RETRY;
                        next_r.hic_cnt = 10'h000;
                        next_r.ss_start = 1'b1;
                    end
                end
            end
            brc_pkg::ST_RETRY: begin
                if (r.blank_cnt == 12'(HIC_BLANK_CYC)) begin
                    next_r.st = brc_pkg::ST_HICCUP;
                    next_r.hic_cnt = 10'h000;
                    next_r.hic_events = (r.hic_events == 8'hff) ? r.hic_events : 8'(r.hic_events + 8'h01);
                end else if (tick) begin
                    next_r.hic_cnt = 10'(r.hic_cnt + 10'h001);
                    if (r.hic_cnt == 10'(`BRC_HIC_RETRY_PER - 1)) begin
                        next_r.st = brc_pkg::ST_RUN;
                        next_r.hic_cnt = 10'h000;
                    end
                end
            end
            default: next_r.st = brc_pkg::ST_OFF;
        endcase
        // shutdown wins over everything and wipes the hiccup, blanking and power-good counters
        if (off_cond) begin
            next_r.st = brc_pkg::ST_OFF;
            next_r.hic_cnt = 10'h000;
            next_r.blank_cnt = 12'h000;
            next_r.pg_cnt = 6'h00;
            next_r.ilim_act = 1'b0;
            next_r.ilim_seen = 1'b0;
            next_r.ss_start = 1'b0;
        end

        // switch sequencing; drivers follow the next supervisor state
        allow = r.sw_run && (next_r.st == brc_pkg::ST_RUN || next_r.st == brc_pkg::ST_RETRY);
        if (!allow) begin
            next_r.hs_req = 1'b0;
            next_r.hs = 1'b0;
            next_r.ls = 1'b0;
            next_r.ls_hold = 1'b0;
            next_r.dead = 4'h0;
        end else begin
            if (r.s2[I_HSL])
                next_r.ls_hold = 1'b1;
            else if (r.ls_hold && !r.s2[I_LSL])
                next_r.ls_hold = 1'b0;
            if (tick && !next_r.ls_hold)
                next_r.hs_req = 1'b1;
            if (r.s2[I_CMP] || r.s2[I_HSL] || next_r.ls_hold)
                next_r.hs_req = 1'b0;
            want_hs = next_r.hs_req;
            // a driver is dropped first, the other waits out the gap
            if (r.hs && !want_hs) begin
                next_r.hs = 1'b0;
                next_r.dead = 4'(DEAD_CYC);
            end else if (r.ls && want_hs) begin
                next_r.ls = 1'b0;
                next_r.dead = 4'(DEAD_CYC);
            end else if (!r.hs && !r.ls) begin
                if (r.dead != 4'h0)
                    next_r.dead = 4'(r.dead - 4'h1);
                else if (want_hs)
                    next_r.hs = 1'b1;
                else
                    next_r.ls = 1'b1;
            end
        end
        next_r.pd = (next_r.st == brc_pkg::ST_OFF || next_r.st == brc_pkg::ST_HICCUP);

        // power-good with deglitch counted in oscillator periods
        if (r.pg ? (r.s2[I_F90] || !r.s2[I_REF]) : (r.s2[I_F925] && r.s2[I_REF])) begin
            if (tick) begin
                next_r.pg_cnt = 6'(r.pg_cnt + 6'h01);
                // first tick may close a partial period, so wait one more
                if (r.pg_cnt == 6'(`BRC_PG_DEGLITCH_PER)) begin
                    next_r.pg = !r.pg;
                    next_r.pg_cnt = 6'h00;
                end
            end
        end else begin
            next_r.pg_cnt = 6'h00;
        end
        if (off_cond) begin
            next_r.pg = 1'b0;
            next_r.pg_cnt = 6'h00;
        end
        next_r.pg_oe = !next_r.pg;

        // apb: one wait state, answer registered
        rdata = 32'h0000_0000;
        rmiss = 1'b0;
        case (PADDR_I)
            `BRC_CTRL_OFS: rdata[`BRC_CTRL_RUN_BIT] = r.sw_run;
            `BRC_STATUS_OFS: begin
                rdata[`BRC_ST_STATE_LSB+:2] = r.st;
                rdata[`BRC_ST_PGOOD_BIT] = r.pg;
                rdata[`BRC_ST_HS_BIT] = r.hs;
                rdata[`BRC_ST_LS_BIT] = r.ls;
                rdata[`BRC_ST_ILIM_BIT] = r.ilim_act;
                rdata[`BRC_ST_PRESET_LSB+:4] = r.preset;
                rdata[`BRC_ST_MODE_LSB+:2] = r.mode;
                rdata[`BRC_ST_PGPIN_BIT] = r.s2[I_PGP];
            end
            `BRC_HICCNT_OFS: rdata[7:0] = r.hic_events;
            default: rmiss = 1'b1;
        endcase
        next_r.pready = PSEL_I && PENABLE_I && !r.pready;
        next_r.pslverr = next_r.pready && rmiss;
        next_r.prdata = (next_r.pready && !PWRITE_I && !rmiss) ? rdata : 32'h0000_0000;
        // write takes effect at the completing edge only
        if (PSEL_I && PENABLE_I && r.pready && PWRITE_I && PADDR_I == `BRC_CTRL_OFS)
            next_r.sw_run = PWDATA_I[`BRC_CTRL_RUN_BIT];
    end

    // single state register; reset gives a quiet, off regulator
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            r <= '0;
            r.st <= brc_pkg::ST_OFF;
            r.sw_run <= 1'b1;
            r.pd <= 1'b1;
            r.pg_oe <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register, power-good pin level tied low
    assign POWER_GOOD_OUT_O = 1'b0;
    assign POWER_GOOD_OUT_OE_O = r.pg_oe;
    assign HS_DRV_O = r.hs;
    assign LS_DRV_O = r.ls;
    assign COMP_PD_O = r.pd;
    assign REF_PD_O = r.pd;
    assign SS_START_O = r.ss_start;
    assign SKIP_MODE_O = r.skip;
    assign PREBIAS_START_O = r.prebias;
    assign PRESET_CODE_O = r.preset;
    assign PRDATA_O = r.prdata;
    assign PREADY_O = r.pready;
    assign PSLVERR_O = r.pslverr;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    a_drivers_exclusive: assert property (!(r.hs && r.ls)) else $error("both drivers on");
    a_hs_off_cmp: assert property (r.hs && r.s2[I_CMP] |=> !r.hs) else $error("high side not cut by ramp");
    a_hs_start: assert property (tick && allow && !r.ls_hold && !r.s2[I_HSL] && !r.s2[I_CMP]
        |-> ##[1:HS_WAIT] (r.hs || !allow)) else $error("high side missed period start");
    a_ls_hold: assert property (r.ls_hold |-> !r.hs) else $error("high side on during hold");
    a_hiccup_quiet: assert property (r.st == brc_pkg::ST_HICCUP |-> !r.hs && !r.ls && COMP_PD_O && REF_PD_O)
        else $error("hiccup not quiet");
    a_hiccup_entry: assert property (r.st == brc_pkg::ST_RUN && !off_cond
        && r.blank_cnt == 12'(HIC_BLANK_CYC) |=> r.st == brc_pkg::ST_HICCUP)
        else $error("no hiccup after blanking");
    a_hiccup_length: assert property (r.st == brc_pkg::ST_HICCUP && tick && !off_cond
        && r.hic_cnt == 10'(`BRC_HIC_OFF_PER - 1) |=> r.st == brc_pkg::ST_RETRY) else $error("hiccup length");
    a_pg_deglitch: assert property ($changed(r.pg) && !$past(off_cond)
        |-> $past(r.pg_cnt) == 6'(`BRC_PG_DEGLITCH_PER) && $past(tick))
        else $error("power-good changed early");
    a_pg_forced: assert property (off_cond |=> POWER_GOOD_OUT_OE_O && !HS_DRV_O && !LS_DRV_O)
        else $error("not forced off");
    a_preset_held: assert property (r.st != brc_pkg::ST_OFF |=> $stable(r.preset)) else $error("preset moved");

    c_hiccup: cover property (r.st == brc_pkg::ST_RUN ##1 r.st == brc_pkg::ST_HICCUP);
    c_retry_run: cover property (r.st == brc_pkg::ST_RETRY ##1 r.st == brc_pkg::ST_RUN);
    c_pg_rise: cover property ($rose(r.pg));
    c_ls_hold: cover property ($rose(r.ls_hold));
endmodule

// ===== bench/brc_stage.sv
/*
 * Behavioural power stage: ramp comparator, switch current limits and
 * feedback comparators seen by the regulator control logic.
 * Assumes driver levels from the control logic and fault knobs from the bench.
 */
`timescale 1ns/10ps
module brc_stage (
    input wire logic clk_i,
    input wire logic hs_i,
    input wire logic ls_i,
    input wire logic overload_i,    // load above high-side limit
    input wire logic fb_ok_i,       // output near set point
    input wire logic short_i,       // output shorted, feedback collapsed
    output logic pwm_cmp_o,
    output logic hs_ilim_o,
    output logic ls_ilim_o,
    output logic fb_low70_o,
    output logic fb_above925_o,
    output logic fb_below90_o
);
    logic [7:0] ramp = 8'h00;   // clocks of high-side conduction
    logic [7:0] drain = 8'h00;  // low-side clocks until current is below limit
    // drain outlasts a period so a tick finds the current still high
    always_ff @(posedge clk_i) begin
        ramp <= hs_i ? ramp + 8'h01 : 8'h00;
        if (overload_i && hs_i) begin
            drain <= 8'h1e;
        end else if (ls_i && drain != 8'h00) begin
            drain <= drain - 8'h01;
        end
    end
    assign pwm_cmp_o = ramp >= 8'h02;
    assign hs_ilim_o = overload_i && hs_i;
    assign ls_ilim_o = drain != 8'h00;
    assign fb_low70_o = short_i;
    assign fb_above925_o = fb_ok_i && !short_i;
    assign fb_below90_o = !fb_ok_i || short_i;
endmodule

// ===== bench/tb.sv
/*
 * Self-checking bench of the regulator control logic with a stage model.
 * Assumes PERIOD_CYC 20, DEAD_CYC 2, HIC_BLANK_CYC 20 to keep runs short.
 */
`timescale 1ns/10ps
`include "brc_map.svh"
module tb;
    localparam int P = 20;  // clocks per oscillator period
    logic clk = 1'b0, srst = 1'b1, en = 1'b0, uvlo = 1'b0, therm = 1'b0;
    logic [1:0] mode = 2'h0, psa = 2'h0, psb = 2'h0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, pg, pg_oe, pg_pin, hs, ls, cpd, rpd, ss, skip, preb, hs_q;
    logic overload = 1'b0, fb_ok = 1'b0, shrt = 1'b0, ref_ok = 1'b1, cmp, hil, lil, f70, f925, f90;
    logic [3:0] code;
    int fails = 0, comparisons = 0, rises = 0, lowlow = 0, both = 0, hson = 0, r0, l0, h0, n;
    assign pg_pin = pg_oe ? pg : 1'b1;  // pull-up when released
    always #2.5 clk = ~clk;
    brc_ctrl #(.PERIOD_CYC(P), .DEAD_CYC(2), .HIC_BLANK_CYC(20)) dut (.CLOCK_I(clk), .SRST_I(srst),
        .EN_I(en), .UVLO_I(uvlo), .THERM_SD_I(therm), .PWM_CMP_I(cmp), .HS_ILIM_I(hil), .LS_ILIM_I(lil),
        .FB_LOW70_I(f70), .FB_ABOVE925_I(f925), .FB_BELOW90_I(f90), .REF_OK_I(ref_ok), .MODE_I(mode),
        .PRESET_SELECT_A_I(psa), .PRESET_SELECT_B_I(psb), .POWER_GOOD_OUT_I(pg_pin),
        .POWER_GOOD_OUT_O(pg), .POWER_GOOD_OUT_OE_O(pg_oe), .HS_DRV_O(hs), .LS_DRV_O(ls),
        .COMP_PD_O(cpd), .REF_PD_O(rpd), .SS_START_O(ss), .SKIP_MODE_O(skip), .PREBIAS_START_O(preb),
        .PRESET_CODE_O(code), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
    brc_stage stage (.clk_i(clk), .hs_i(hs), .ls_i(ls), .overload_i(overload), .fb_ok_i(fb_ok),
        .short_i(shrt), .pwm_cmp_o(cmp), .hs_ilim_o(hil), .ls_ilim_o(lil), .fb_low70_o(f70),
        .fb_above925_o(f925), .fb_below90_o(f90));
    // driver activity counters, read only at falling edges
    always @(posedge clk) begin
        hs_q <= hs;
        if (hs === 1'b1 && hs_q === 1'b0) rises++;
        if (!hs && !ls) lowlow++;
        if (hs) hson++;
        if (hs && ls) both++;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);  // a wait that runs out counts as a mismatch
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task per(input int k);
        repeat (k * P) @(posedge clk);
        @(negedge clk);
    endtask
    task t_reset();
        @(negedge clk);
        chk({hs, ls, pg_oe, cpd, rpd}, 32'h7);
        apb(1'b0, `BRC_CTRL_OFS, 32'h0);
        chk(q, `BRC_CTRL_RST);
        apb(1'b0, 12'hffc, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task t_select();
        for (int a = 0; a < 3; a++) begin
            for (int b = 0; b < 3; b++) begin
                @(posedge clk);
                psa <= 2'(a);
                psb <= 2'(b);
                per(1);
                chk(code, 32'(a * 3 + b));
            end
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode <= 2'(m);
            per(1);
            chk({skip, preb}, (m == 0) ? 32'h0 : (m == 1) ? 32'h1 : 32'h3);
        end
        @(posedge clk);
        psa <= 2'h1;
        psb <= 2'h1;
        per(1);
        $display("test select done");
    endtask
    // presets stay untouched from here on while enabled
    task t_switch();
        @(posedge clk);
        en <= 1'b1;
        per(20);
        {r0, l0, h0} = {rises, lowlow, hson};
        per(10);
        chk(rises - r0, 32'd10);
        chk(lowlow - l0, 32'd60);
        chk((hson - h0 > 10) && (hson - h0 < 100), 32'h1);
        chk({cpd, rpd, code}, 32'h4);
        $display("test switch done");
    endtask
    task t_pgood();
        @(posedge clk);
        fb_ok <= 1'b1;
        per(40);
        chk(pg_oe, 32'h1);
        per(12);
        chk({pg_oe, pg_pin}, 32'h1);
        @(posedge clk);
        fb_ok <= 1'b0;
        per(40);
        chk(pg_oe, 32'h0);
        per(12);
        chk({pg_oe, pg}, 32'h2);
        // reference low keeps power-good off whatever the feedback says
        @(posedge clk);
        ref_ok <= 1'b0;
        fb_ok <= 1'b1;
        per(52);
        chk(pg_oe, 32'h1);
        @(posedge clk);
        ref_ok <= 1'b1;
        per(52);
        apb(1'b0, `BRC_STATUS_OFS, 32'h0);
        chk({q[`BRC_ST_PGPIN_BIT], q[`BRC_ST_PGOOD_BIT], pg_oe}, 32'h6);
        @(posedge clk);
        ref_ok <= 1'b0;
        per(52);
        chk(pg_oe, 32'h1);
        @(posedge clk);
        ref_ok <= 1'b1;
        fb_ok <= 1'b0;
        $display("test pgood done");
    endtask
    task t_hiccup();
        @(posedge clk);
        overload <= 1'b1;
        per(2);
        r0 = rises;
        per(10);
        chk(rises - r0 < 10, 32'h1);
        @(posedge clk);
        shrt <= 1'b1;
        n = 0;
        while (cpd !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk({hs, ls, cpd, rpd}, 32'h3);
        @(posedge clk);
        shrt <= 1'b0;
        overload <= 1'b0;
        apb(1'b0, `BRC_STATUS_OFS, 32'h0);
        chk(q[1:0], brc_pkg::ST_HICCUP);
        per(888);
        apb(1'b0, `BRC_STATUS_OFS, 32'h0);
        chk({q[1:0], hs, ls, rpd}, {brc_pkg::ST_HICCUP, 3'h1});
        per(10);
        apb(1'b0, `BRC_STATUS_OFS, 32'h0);
        chk(q[1:0], brc_pkg::ST_RETRY);
        per(115);
        apb(1'b0, `BRC_STATUS_OFS, 32'h0);
        chk({q[1:0], cpd, rpd}, {brc_pkg::ST_RUN, 2'h0});
        $display("test hiccup done");
    endtask
    task t_off();
        @(posedge clk);
        uvlo <= 1'b1;
        per(1);
        chk({hs, ls, pg_oe}, 32'h1);
        @(posedge clk);
        uvlo <= 1'b0;
        n = 0;
        while (ss !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(ss, 32'h1);
        @(posedge clk);
        therm <= 1'b1;
        per(1);
        chk({hs, ls, pg_oe}, 32'h1);
        @(posedge clk);
        therm <= 1'b0;
        apb(1'b1, `BRC_CTRL_OFS, 32'h0);
        per(1);
        chk({hs, ls}, 32'h0);
        apb(1'b1, `BRC_STATUS_OFS, 32'hffff_ffff);
        chk(e, 32'h0);
        apb(1'b0, `BRC_CTRL_OFS, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, `BRC_CTRL_OFS, 32'h1);
        en <= 1'b0;
        per(1);
        chk({hs, ls, cpd, rpd, pg_oe}, 32'h7);
        chk(both, 32'h0);
        $display("test off done");
    endtask
    task close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, well beyond the hiccup span
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_select();
        t_switch();
        t_pgood();
        t_hiccup();
        t_off();
        close_out();
    end
endmodule
